// [clk_cfg_pkg.sv]
// Constants for the clock generator mode configuration block
package clk_cfg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Control register one fields
    // ------------------------------------------------------------
    localparam int GAIN_BIT = 7;
    localparam int RANGE_BIT = 6;
    localparam int REFSEL_BIT = 5;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 3;
    localparam int KEEP_BIT = 2;
    localparam int LOSS_OF_CLOCK_DISABLE_BIT = 1;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int ST_MODE_HI = 1;
    localparam int ST_MODE_LO = 0;
    localparam int ST_REF_SELECT_STATUS_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_PIN_BIT = 4;
    localparam int ST_FIRST_BIT = 5;
    localparam int ST_OSC_BIT = 6;
    localparam int ST_ERVALID_BIT = 7;

    // ------------------------------------------------------------
    // Clock modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SELF_CLOCKED = 2'h0;
    localparam logic [1:0] MODE_FLL_ENG_INT = 2'h1;
    localparam logic [1:0] MODE_FLL_BYP_EXT = 2'h2;
    localparam logic [1:0] MODE_FLL_ENG_EXT = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MODE_SYNC_NS = 400;
    localparam int MODE_SYNC_CYCLES_INT = (MODE_SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] MODE_SYNC_CYCLES = 3'(MODE_SYNC_CYCLES_INT);

endpackage

// [level_sync.sv]
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module level_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_reg;

    // ------------------------------------------------------------
    // Capture chain
    // ------------------------------------------------------------
    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// [axil_regs_slave.sv]
// AXI4-Lite slave front end with one write and one read in flight
`timescale 1ns/1ns
module axil_regs_slave (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wr_ok,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic [7:0] rd_addr
);

    logic aw_hold_reg;
    logic w_hold_reg;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    // Commit once both halves are held and no answer is pending
    assign wr_en = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign rd_addr = s_axi_araddr;

    // Address and data are taken in either order
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_hold_reg <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end else if (wr_en) begin
                aw_hold_reg <= 1'b0;
            end else if (!aw_hold_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_hold_reg <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end else if (wr_en) begin
                w_hold_reg <= 1'b0;
            end else if (!w_hold_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write answer follows the commit by one edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= clk_cfg_pkg::RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? clk_cfg_pkg::RESP_OKAY : clk_cfg_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Data captured at the address handshake
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= clk_cfg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? clk_cfg_pkg::RESP_OKAY : clk_cfg_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// [clock_gen_mode_config.sv]
// Clock generator mode configuration: control register one and pin use
//
// Notes on behaviour
// - External modes on first write reserve input pin
// - Internal modes on first write leave pins unused
// - External modes use output pin as oscillator drive
// - Gain bit: zero low power, one high gain
// - Gain, range, reference select write once only
// - Range bit: zero prescale 64, one prescale 1
// - Range bit matters only in external modes
// - Reference select: zero clock, one crystal
// - Mode field selects one of four modes
// - Bypassed external waits for valid external reference
// - Off mode leaves mode field unchanged
// - Mode write ignored while previous one pending
// - First internal mode blocks later external modes
// - Keep bit one runs oscillator in off mode
// - Keep bit zero stops oscillator, with exception
// - Keep bit ignored when gain and range set
// - Loss of clock bit one disables detection
// - Reference status: zero clock, one crystal
// - Reset enters self clocked mode
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module clock_gen_mode_config (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_ref_clock_valid,
    input wire logic off_mode,
    input wire logic off_osc_enable,
    output logic high_gain_osc_select,
    output logic freq_range_high,
    output logic prescale_is_64,
    output logic [1:0] clock_mode_status,
    output logic ref_select_status,
    output logic ext_clock_in_pin_used,
    output logic ext_clock_in_is_osc,
    output logic osc_out_pin_drive,
    output logic osc_enable,
    output logic loss_of_clock_detect_en,
    output logic mode_switch_busy
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic gain_reg;
    logic range_reg;
    logic refsel_reg;
    logic [1:0] mode_req_reg;
    logic keep_reg;
    logic loss_of_clock_disable_reg;
    logic first_done_reg;
    logic ext_blocked_reg;
    logic pin_reserved_reg;
    logic [1:0] mode_pend_reg;
    logic [2:0] mode_cnt_reg;
    logic ext_valid_sync;
    logic bus_wr_en;
    logic [7:0] bus_wr_addr;
    logic [31:0] bus_wr_data;
    logic [3:0] bus_wr_strb;
    logic [7:0] bus_rd_addr;
    logic [31:0] bus_rd_data;
    logic bus_rd_ok;
    logic bus_wr_ok;
    logic ctrl_wr;
    logic [1:0] wr_mode;
    logic mode_accept;
    logic osc_enable_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // True for a known register address, used by both bus paths
    function automatic logic addr_mapped(input logic [7:0] addr);
        return (addr == clk_cfg_pkg::CTRL_ONE_ADDR) || (addr == clk_cfg_pkg::STATUS_ADDR);
    endfunction

    // ------------------------------------------------------------
    // Bus front end and input synchroniser
    // ------------------------------------------------------------
    axil_regs_slave u_bus (
        .clk(clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_ok(bus_wr_ok),
        .rd_data(bus_rd_data),
        .rd_ok(bus_rd_ok),
        .wr_en(bus_wr_en),
        .wr_addr(bus_wr_addr),
        .wr_data(bus_wr_data),
        .wr_strb(bus_wr_strb),
        .rd_addr(bus_rd_addr)
    );

    // Reference monitor runs off the external clock
    level_sync u_ervalid_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(ext_ref_clock_valid),
        .sync_out(ext_valid_sync)
    );

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Status register is read only; writes to it answer OKAY and do nothing
    assign bus_wr_ok = addr_mapped(bus_wr_addr);
    // Frozen block takes no writes; the bus still answers
    assign ctrl_wr = bus_wr_en && clk_en && bus_wr_strb[0]
        && (bus_wr_addr == clk_cfg_pkg::CTRL_ONE_ADDR);
    assign wr_mode = bus_wr_data[clk_cfg_pkg::MODE_HI:clk_cfg_pkg::MODE_LO];
    // Mode write refused while busy or asking for a pin never reserved
    assign mode_accept = ctrl_wr && !mode_switch_busy
        && !(ext_blocked_reg && wr_mode[1]);

    // Write-once oscillator fields and pin reservation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_reg <= 1'b0;
            range_reg <= 1'b0;
            refsel_reg <= 1'b0;
            first_done_reg <= 1'b0;
            ext_blocked_reg <= 1'b0;
            pin_reserved_reg <= 1'b0;
        end else if (ctrl_wr && !first_done_reg) begin
            gain_reg <= bus_wr_data[clk_cfg_pkg::GAIN_BIT];
            range_reg <= bus_wr_data[clk_cfg_pkg::RANGE_BIT];
            refsel_reg <= bus_wr_data[clk_cfg_pkg::REFSEL_BIT];
            first_done_reg <= 1'b1;
            ext_blocked_reg <= !wr_mode[1];
            pin_reserved_reg <= wr_mode[1];
        end
    end

    // Freely writable bits; bit zero has no storage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            keep_reg <= 1'b0;
            loss_of_clock_disable_reg <= 1'b0;
        end else if (ctrl_wr) begin
            keep_reg <= bus_wr_data[clk_cfg_pkg::KEEP_BIT];
            loss_of_clock_disable_reg <= bus_wr_data[clk_cfg_pkg::LOSS_OF_CLOCK_DISABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Mode switching
    // ------------------------------------------------------------
    // Request settles for a fixed time, then bypass waits for the reference.
    // Off mode never touches the requested field.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_req_reg <= clk_cfg_pkg::MODE_SELF_CLOCKED;
            mode_pend_reg <= clk_cfg_pkg::MODE_SELF_CLOCKED;
            clock_mode_status <= clk_cfg_pkg::MODE_SELF_CLOCKED;
            mode_cnt_reg <= 3'h0;
            mode_switch_busy <= 1'b0;
        end else if (clk_en) begin
            if (mode_accept) begin
                mode_req_reg <= wr_mode;
                mode_pend_reg <= wr_mode;
                mode_cnt_reg <= clk_cfg_pkg::MODE_SYNC_CYCLES - 3'h1;
                mode_switch_busy <= 1'b1;
            end else if (mode_switch_busy) begin
                if (mode_cnt_reg != 3'h0) begin
                    mode_cnt_reg <= mode_cnt_reg - 3'h1;
                end else if (mode_pend_reg != clk_cfg_pkg::MODE_FLL_BYP_EXT
                        || ext_valid_sync) begin
                    clock_mode_status <= mode_pend_reg;
                    mode_switch_busy <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator enable
    // ------------------------------------------------------------
    // With high gain and high range the keep bit drops out of the choice
    always_comb begin
        if (!off_mode) begin
            osc_enable_next = pin_reserved_reg && refsel_reg;
        end else if (keep_reg && !(gain_reg && range_reg)) begin
            osc_enable_next = mode_req_reg[1] && ref_select_status;
        end else begin
            osc_enable_next = off_osc_enable && ref_select_status
                && (mode_req_reg == clk_cfg_pkg::MODE_FLL_BYP_EXT);
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Range only reaches the loop in external modes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            high_gain_osc_select <= 1'b0;
            freq_range_high <= 1'b0;
            prescale_is_64 <= 1'b0;
            ref_select_status <= 1'b0;
            ext_clock_in_pin_used <= 1'b0;
            ext_clock_in_is_osc <= 1'b0;
            osc_out_pin_drive <= 1'b0;
            osc_enable <= 1'b0;
            loss_of_clock_detect_en <= 1'b1;
        end else if (clk_en) begin
            high_gain_osc_select <= gain_reg;
            freq_range_high <= range_reg && clock_mode_status[1];
            prescale_is_64 <= !range_reg && clock_mode_status[1];
            ref_select_status <= refsel_reg;
            ext_clock_in_pin_used <= pin_reserved_reg;
            ext_clock_in_is_osc <= pin_reserved_reg && refsel_reg;
            osc_out_pin_drive <= pin_reserved_reg;
            osc_enable <= osc_enable_next;
            loss_of_clock_detect_en <= !loss_of_clock_disable_reg;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    assign bus_rd_ok = addr_mapped(bus_rd_addr);

    // Bit zero of control register one and the upper bytes read as zero
    always_comb begin
        bus_rd_data = 32'h00000000;
        if (bus_rd_addr == clk_cfg_pkg::CTRL_ONE_ADDR) begin
            bus_rd_data[clk_cfg_pkg::GAIN_BIT] = gain_reg;
            bus_rd_data[clk_cfg_pkg::RANGE_BIT] = range_reg;
            bus_rd_data[clk_cfg_pkg::REFSEL_BIT] = refsel_reg;
            bus_rd_data[clk_cfg_pkg::MODE_HI:clk_cfg_pkg::MODE_LO] = mode_req_reg;
            bus_rd_data[clk_cfg_pkg::KEEP_BIT] = keep_reg;
            bus_rd_data[clk_cfg_pkg::LOSS_OF_CLOCK_DISABLE_BIT] = loss_of_clock_disable_reg;
        end else if (bus_rd_addr == clk_cfg_pkg::STATUS_ADDR) begin
            bus_rd_data[clk_cfg_pkg::ST_MODE_HI:clk_cfg_pkg::ST_MODE_LO] = clock_mode_status;
            bus_rd_data[clk_cfg_pkg::ST_REF_SELECT_STATUS_BIT] = ref_select_status;
            bus_rd_data[clk_cfg_pkg::ST_BUSY_BIT] = mode_switch_busy;
            bus_rd_data[clk_cfg_pkg::ST_PIN_BIT] = pin_reserved_reg;
            bus_rd_data[clk_cfg_pkg::ST_FIRST_BIT] = first_done_reg;
            bus_rd_data[clk_cfg_pkg::ST_OSC_BIT] = osc_enable;
            bus_rd_data[clk_cfg_pkg::ST_ERVALID_BIT] = ext_valid_sync;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence first_ctrl_write;
        ctrl_wr && !first_done_reg;
    endsequence

    sequence settle_window;
        (mode_switch_busy && $stable(clock_mode_status)) [*4];
    endsequence

    chk_write_once_fields: assert property (
        first_done_reg && !$past(sys_rst) |=> $stable({gain_reg, range_reg, refsel_reg}))
        else $error("write-once field changed after first write");

    chk_pin_reservation: assert property (
        first_ctrl_write |=> pin_reserved_reg == $past(wr_mode[1]) ##1
            (!$past(clk_en) || ext_clock_in_pin_used == pin_reserved_reg))
        else $error("pin reservation does not follow first mode");

    chk_external_block: assert property (
        ext_blocked_reg |-> !mode_req_reg[1])
        else $error("external mode accepted after internal first write");

    chk_busy_write_drop: assert property (
        mode_switch_busy && ctrl_wr |=> $stable(mode_req_reg))
        else $error("mode write taken while previous one pending");

    chk_mode_settle: assert property (
        mode_accept |=> settle_window)
        else $error("mode status changed before settle time");

    chk_bypass_wait: assert property (
        mode_switch_busy && mode_cnt_reg == 3'h0 && !ext_valid_sync
            && mode_pend_reg == clk_cfg_pkg::MODE_FLL_BYP_EXT |=> mode_switch_busy)
        else $error("bypass mode entered without valid reference");

    chk_reset_mode: assert property (
        $past(sys_rst) |-> clock_mode_status == clk_cfg_pkg::MODE_SELF_CLOCKED
            && mode_req_reg == clk_cfg_pkg::MODE_SELF_CLOCKED)
        else $error("block left reset outside self clocked mode");

    chk_range_gate: assert property (
        clk_en && !clock_mode_status[1] |=> !freq_range_high && !prescale_is_64)
        else $error("range active in an internal mode");

    chk_off_keep: assert property (
        clk_en && off_mode && keep_reg && !(gain_reg && range_reg)
            && mode_req_reg[1] && ref_select_status |=> osc_enable)
        else $error("oscillator not kept in off mode");

    chk_loss_detect: assert property (
        clk_en |=> loss_of_clock_detect_en == !$past(loss_of_clock_disable_reg))
        else $error("loss of clock enable does not follow control bit");

endmodule

// [ext_ref_source.sv]
// Partner model: external reference source with a start-up delay
`timescale 1ns/1ns
module ext_ref_source #(
    parameter int START_CYCLES = 6
) (
    input wire logic clk,
    input wire logic run,
    output logic ref_good = 1'b0
);
    int cnt = 0;

    // Good only after a slow start, so a premature mode switch shows up
    always @(posedge clk) begin
        cnt <= run ? cnt + 1 : 0;
        ref_good <= run && cnt >= START_CYCLES;
    end
endmodule

// [clock_gen_mode_config_test.sv]
// Self-checking bench for the clock generator mode configuration block
`timescale 1ns/1ns
module clock_gen_mode_config_test;
    localparam logic [7:0] CA = clk_cfg_pkg::CTRL_ONE_ADDR;
    localparam logic [1:0] OK = clk_cfg_pkg::RESP_OKAY;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, off_mode = 1'b0, off_osc_enable = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, src_run = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, clock_mode_status;
    logic [31:0] s_axi_rdata;
    logic high_gain_osc_select, freq_range_high, prescale_is_64, ref_select_status;
    logic ext_clock_in_pin_used, ext_clock_in_is_osc, osc_out_pin_drive, osc_enable;
    logic loss_of_clock_detect_en, mode_switch_busy, ext_ref_clock_valid;
    logic [7:0] m, wd[3];
    logic first, ext;
    int n_errors = 0, total_checks = 0;

    clock_gen_mode_config u_clock_gen_mode_config (.*);
    ext_ref_source #(.START_CYCLES(6)) u_ext_ref_source (.clk(clk), .run(src_run),
        .ref_good(ext_ref_clock_valid));

    // 10 MHz clock
    always #50 clk = ~clk;

    // ------------------------------------------------------------
    // Bus cycles, reference model and comparisons
    // ------------------------------------------------------------
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Outputs expected from the model once the mode has settled
    task automatic chk_pins(input logic [1:0] md);
        chk_val("pins", {m[7], m[6] & md[1], !m[6] & md[1], md, m[5], ext, ext & m[5], ext,
            !m[1], 1'b0}, {high_gain_osc_select, freq_range_high, prescale_is_64,
            clock_mode_status, ref_select_status, ext_clock_in_pin_used, ext_clock_in_is_osc,
            osc_out_pin_drive, loss_of_clock_detect_en, mode_switch_busy});
    endtask

    // Write-once fields latch on the first write only
    task automatic model_wr(input logic [7:0] d);
        if (!first) begin
            m = d & 8'hfe;
            ext = d[4];
            first = 1'b1;
        end else begin
            m[2:1] = d[2:1];
            if (ext || !d[4]) m[4:3] = d[4:3];
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk_val("bresp", er, s_axi_bresp);
        if (a == CA) model_wr(d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_val("rdata", exp, s_axi_rdata);
        chk_val("rresp", a == CA ? OK : clk_cfg_pkg::RESP_SLVERR, s_axi_rresp);
    endtask

    // Settle span: eight cycles, room for four sync cycles plus output register
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        first = 1'b0;
        ext = 1'b0;
        m = clk_cfg_pkg::CTRL_ONE_RESET;
        @(posedge clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Watchdog: the whole run needs well under 3000 cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    initial begin
        void'($urandom(95043));
        wd = '{8'hb8, 8'hbc, 8'hfc};
        do_reset();
        rd(CA, {24'h0, m});
        chk_pins(2'h0);
        src_run <= 1'b1;
        wr(8'h08, 8'hff, clk_cfg_pkg::RESP_SLVERR);
        rd(8'h08, 32'h0);
        wr(CA, 8'hff, OK);
        settle();
        rd(CA, {24'h0, m});
        chk_pins(2'h3);
        wr(CA, 8'h00, OK);
        settle();
        rd(CA, {24'h0, m});
        chk_pins(2'h0);
        $display("test first write done");
        // Keep bit in off mode: no keep, plain keep, keep overridden by gain and range
        for (int k = 0; k < 3; k++) begin
            do_reset();
            wr(CA, wd[k] | (8'($urandom) & 8'h03), OK);
            off_mode <= 1'b1;
            settle();
            chk_val("osc_en", k == 1, osc_enable);
        end
        wr(CA, 8'hf0, OK);
        off_osc_enable <= 1'b1;
        settle();
        chk_val("osc_en", 1'b1, osc_enable);
        rd(CA, {24'h0, m});
        off_mode <= 1'b0;
        off_osc_enable <= 1'b0;
        $display("test off mode done");
        src_run <= 1'b0;
        do_reset();
        wr(CA, 8'h10, OK);
        settle();
        chk_val("mode", 2'h0, clock_mode_status);
        src_run <= 1'b1;
        for (int i = 0; i < 40 && clock_mode_status !== 2'h2; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk_pins(2'h2);
        $display("test bypass wait done");
        do_reset();
        wr(CA, 8'h08, OK);
        chk_val("busy", 1'b1, mode_switch_busy);
        // Second write lands while the first mode is still settling
        wr(CA, 8'h00, OK);
        m[4:3] = 2'h1;
        settle();
        wr(CA, 8'h18, OK);
        settle();
        rd(CA, {24'h0, m});
        chk_pins(2'h1);
        // Frozen block answers the bus but stores nothing
        clk_en <= 1'b0;
        wr(CA, 8'h0e, OK);
        clk_en <= 1'b1;
        m[2:1] = 2'h0;
        settle();
        rd(CA, {24'h0, m});
        chk_pins(2'h1);
        $display("test internal lock done");
        give_verdict();
    end
endmodule
